// ### rtl/bams_params.svh
// Purpose: address map, bit positions and counts of the abort and mailbox status block
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   included by every design file that needs a number
`ifndef BAMS_PARAMS_SVH
`define BAMS_PARAMS_SVH

`define BAMS_ADDR_W        8
`define BAMS_DATA_W        32
`define BAMS_STRB_W        4

`define BAMS_OFF_ICS       8'h00
`define BAMS_OFF_EVT       8'h04
`define BAMS_OFF_MASK      8'h08
`define BAMS_OFF_RCNT      8'h0C

`define BAMS_BIT_MBEN      3
`define BAMS_BIT_DM_ABT    24
`define BAMS_BIT_DMA0_ABT  25
`define BAMS_BIT_DMA1_ABT  26
`define BAMS_BIT_RTY_ABT   27
`define BAMS_BIT_MB_LO     28

`define BAMS_N_MBOX        4
`define BAMS_N_EVT         8
`define BAMS_EVT_DM        0
`define BAMS_EVT_DMA0      1
`define BAMS_EVT_DMA1      2
`define BAMS_EVT_RTY       3
`define BAMS_EVT_MB_LO     4

`define BAMS_RETRY_LIMIT   256
`define BAMS_CNT_W         9

`define BAMS_RESP_OKAY     2'h0
`define BAMS_RESP_SLVERR   2'h2

`endif

// ### rtl/bams_pkg.sv
// Purpose: types shared by the abort and mailbox status block
// Assumes: numbers live in bams_params.svh
// Notes:   bus owner is one-hot so an idle bus is simply no code
package bams_pkg;

  typedef enum logic [2:0] {
    BAMS_OWN_DM   = 3'h1,
    BAMS_OWN_DMA0 = 3'h2,
    BAMS_OWN_DMA1 = 3'h4
  } bams_owner_t;

endpackage : bams_pkg

// ### rtl/bams_reg_if.sv
// Purpose: register access strobes between the bus slave and the register file
// Assumes: one write pulse per accepted write, read decode is combinational
// Notes:   hit flags come back from the register file for the bus response
`timescale 1ns/100ps
`include "bams_params.svh"
interface bams_reg_if;
  logic                       wr_pulse;
  logic [`BAMS_ADDR_W-1:0]    wr_addr;
  logic [`BAMS_DATA_W-1:0]    wr_data;
  logic [`BAMS_STRB_W-1:0]    wr_strb;
  logic                       wr_hit;
  logic [`BAMS_ADDR_W-1:0]    rd_addr;
  logic [`BAMS_DATA_W-1:0]    rd_data;
  logic                       rd_hit;

  modport bus  (output wr_pulse, wr_addr, wr_data, wr_strb, rd_addr, input wr_hit, rd_data, rd_hit);
  modport regs (input wr_pulse, wr_addr, wr_data, wr_strb, rd_addr, output wr_hit, rd_data, rd_hit);
endinterface : bams_reg_if

// ### rtl/bams_axil.sv
// Purpose: AXI4-Lite slave front end of the status block
// Assumes: one write and one read outstanding at most
// Notes:   write fires in the same cycle that both address and data are held
`timescale 1ns/100ps
`include "bams_params.svh"
module bams_axil import bams_pkg::*; (
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // write address and data
  input  wire logic [`BAMS_ADDR_W-1:0] awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [`BAMS_DATA_W-1:0] wdata,
  input  wire logic [`BAMS_STRB_W-1:0] wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  // write response
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  // read
  input  wire logic [`BAMS_ADDR_W-1:0] araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [`BAMS_DATA_W-1:0]      rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  // register file side
  bams_reg_if.bus                      rif
);
  logic                      aw_held_r;
  logic                      w_held_r;
  logic [`BAMS_ADDR_W-1:0]   awaddr_r;
  logic [`BAMS_DATA_W-1:0]   wdata_r;
  logic [`BAMS_STRB_W-1:0]   wstrb_r;
  logic                      awready_r;
  logic                      wready_r;
  logic                      bvalid_r;
  logic [1:0]                bresp_r;
  logic                      arready_r;
  logic                      rvalid_r;
  logic [1:0]                rresp_r;
  logic [`BAMS_DATA_W-1:0]   rdata_r;
  wire                       aw_hs = awvalid && awready_r;
  wire                       w_hs  = wvalid && wready_r;
  wire                       ar_hs = arvalid && arready_r;
  wire                       fire  = aw_held_r && w_held_r;

  assign rif.wr_pulse = fire;
  assign rif.wr_addr  = awaddr_r;
  assign rif.wr_data  = wdata_r;
  assign rif.wr_strb  = wstrb_r;
  assign rif.rd_addr  = araddr;
  assign awready      = awready_r;
  assign wready       = wready_r;
  assign bvalid       = bvalid_r;
  assign bresp        = bresp_r;
  assign arready      = arready_r;
  assign rvalid       = rvalid_r;
  assign rresp        = rresp_r;
  assign rdata        = rdata_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awready_r <= 1'b1;
      awaddr_r  <= '0;
    end else if (aw_hs) begin
      aw_held_r <= 1'b1;
      awready_r <= 1'b0;
      awaddr_r  <= awaddr;
    end else if (fire) begin
      aw_held_r <= 1'b0;
    end else if (bvalid_r && bready) begin
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wready_r <= 1'b1;
      wdata_r  <= '0;
      wstrb_r  <= '0;
    end else if (w_hs) begin
      w_held_r <= 1'b1;
      wready_r <= 1'b0;
      wdata_r  <= wdata;
      wstrb_r  <= wstrb;
    end else if (fire) begin
      w_held_r <= 1'b0;
    end else if (bvalid_r && bready) begin
      wready_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `BAMS_RESP_OKAY;
    end else if (fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= rif.wr_hit ? `BAMS_RESP_OKAY : `BAMS_RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= `BAMS_RESP_OKAY;
      rdata_r   <= '0;
    end else if (ar_hs) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= rif.rd_hit ? `BAMS_RESP_OKAY : `BAMS_RESP_SLVERR;
      rdata_r   <= rif.rd_data;
    end else if (rvalid_r && rready) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end
endmodule : bams_axil

// ### rtl/bams_top.sv
// Purpose: abort owner, retry abort and mailbox-written status of a bus bridge
// Assumes: event inputs are one-cycle pulses synchronous to aclk
// Notes:   status word bits 24..27 read 0 after an event, bits 28..31 read 1
//
// Notes on behaviour
// [RQ1] Bit 24 reads 0 once an abort happened while the direct master owned the bus, and 1 from reset.
// [RQ2] Bit 25 reads 0 once an abort happened while DMA channel 0 owned the bus, and 1 from reset.
// [RQ3] Bit 26 reads 0 once an abort happened while DMA channel 1 owned the bus, and 1 from reset.
// [RQ4] Bit 27 goes to 0 when the bridge issues a target abort after 256 consecutive retries, 1 from reset.
// [RQ5] Bits 28 to 31 go to 1 when the host side writes mailbox 0 to 3, and read 0 from reset.
// [RQ6] A mailbox flag is recorded only while the mailbox enable at bit 3 is set.
`timescale 1ns/100ps
`include "bams_params.svh"
module bams_top import bams_pkg::*; #(
  parameter int RETRY_LIMIT = `BAMS_RETRY_LIMIT,
  parameter int CNT_W       = `BAMS_CNT_W
) (
  // clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // axi4-lite write
  input  wire logic [`BAMS_ADDR_W-1:0]    awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [`BAMS_DATA_W-1:0]    wdata,
  input  wire logic [`BAMS_STRB_W-1:0]    wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  // axi4-lite read
  input  wire logic [`BAMS_ADDR_W-1:0]    araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [`BAMS_DATA_W-1:0]         rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  // bridge events
  input  wire logic                       abort_evt,
  input  wire bams_owner_t                abort_owner,
  input  wire logic                       retry_evt,
  input  wire logic                       retry_clr,
  input  wire logic [`BAMS_N_MBOX-1:0]    mbox_wr,
  // outputs
  output logic                            tabort_issue,
  output logic                            irq
);
  generate
    if (RETRY_LIMIT < 2 || RETRY_LIMIT > (1 << CNT_W)) begin : g_bad_limit
      $error("bams_top: RETRY_LIMIT does not fit the retry counter");
    end
  endgenerate

  bams_reg_if rif ();

  bams_axil u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .rif     (rif)
  );

  logic                       mbox_en_r;
  logic [`BAMS_N_EVT-1:0]     evt_r;
  logic [`BAMS_N_EVT-1:0]     mask_r;
  logic [CNT_W-1:0]           cnt_r;
  logic [CNT_W-1:0]           cnt_nxt;
  logic                       tabort_r;
  logic                       irq_r;
  logic [`BAMS_N_EVT-1:0]     evt_set;
  logic [`BAMS_N_EVT-1:0]     evt_clr;
  logic [`BAMS_DATA_W-1:0]    ics_word;
  logic [`BAMS_DATA_W-1:0]    evt_word;
  logic [`BAMS_DATA_W-1:0]    mask_word;
  logic [`BAMS_DATA_W-1:0]    rcnt_word;

  // address decode
  wire wr_lo      = rif.wr_pulse && rif.wr_strb[0];
  wire wr_ics     = wr_lo && rif.wr_addr == `BAMS_OFF_ICS;
  wire wr_evt     = wr_lo && rif.wr_addr == `BAMS_OFF_EVT;
  wire wr_mask    = wr_lo && rif.wr_addr == `BAMS_OFF_MASK;
  wire rd_ics     = rif.rd_addr == `BAMS_OFF_ICS;
  wire rd_evt     = rif.rd_addr == `BAMS_OFF_EVT;
  wire rd_mask    = rif.rd_addr == `BAMS_OFF_MASK;
  wire rd_rcnt    = rif.rd_addr == `BAMS_OFF_RCNT;
  wire retry_hit  = retry_evt && cnt_r == CNT_W'(RETRY_LIMIT - 1);

  assign rif.wr_hit = rif.wr_addr == `BAMS_OFF_ICS || rif.wr_addr == `BAMS_OFF_EVT ||
                      rif.wr_addr == `BAMS_OFF_MASK || rif.wr_addr == `BAMS_OFF_RCNT;
  assign rif.rd_hit = rd_ics || rd_evt || rd_mask || rd_rcnt;

  // status word: abort bits active low, mailbox bits active high
  always_comb begin
    ics_word                       = '0;
    ics_word[`BAMS_BIT_MBEN]       = mbox_en_r;
    ics_word[`BAMS_BIT_DM_ABT]     = ~evt_r[`BAMS_EVT_DM];   // RQ1
    ics_word[`BAMS_BIT_DMA0_ABT]   = ~evt_r[`BAMS_EVT_DMA0]; // RQ2
    ics_word[`BAMS_BIT_DMA1_ABT]   = ~evt_r[`BAMS_EVT_DMA1]; // RQ3
    ics_word[`BAMS_BIT_RTY_ABT]    = ~evt_r[`BAMS_EVT_RTY];  // RQ4
    ics_word[`BAMS_BIT_MB_LO +: `BAMS_N_MBOX] = evt_r[`BAMS_EVT_MB_LO +: `BAMS_N_MBOX]; // RQ5
  end

  assign evt_word  = {{(`BAMS_DATA_W-`BAMS_N_EVT){1'b0}}, evt_r};
  assign mask_word = {{(`BAMS_DATA_W-`BAMS_N_EVT){1'b0}}, mask_r};
  assign rcnt_word = {{(`BAMS_DATA_W-CNT_W){1'b0}}, cnt_r};
  assign rif.rd_data = rd_ics  ? ics_word  :
                       rd_evt  ? evt_word  :
                       rd_mask ? mask_word :
                       rd_rcnt ? rcnt_word : '0;

  // event sources
  assign evt_set[`BAMS_EVT_DM]   = abort_evt && abort_owner == BAMS_OWN_DM;   // RQ1
  assign evt_set[`BAMS_EVT_DMA0] = abort_evt && abort_owner == BAMS_OWN_DMA0; // RQ2
  assign evt_set[`BAMS_EVT_DMA1] = abort_evt && abort_owner == BAMS_OWN_DMA1; // RQ3
  assign evt_set[`BAMS_EVT_RTY]  = retry_hit;                                 // RQ4
  assign evt_clr = wr_evt ? rif.wr_data[`BAMS_N_EVT-1:0] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < `BAMS_N_MBOX; gi++) begin : g_mbox
      assign evt_set[`BAMS_EVT_MB_LO + gi] = mbox_wr[gi] && mbox_en_r; // RQ5 RQ6
    end
    for (gi = 0; gi < `BAMS_N_EVT; gi++) begin : g_evt
      // set beats a same-cycle clear
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          evt_r[gi] <= 1'b0;
        end else begin
          evt_r[gi] <= evt_set[gi] || (evt_r[gi] && !evt_clr[gi]);
        end
      end
    end
  endgenerate

  // consecutive retry counter, a completed transfer restarts it
  assign cnt_nxt = (retry_clr || retry_hit) ? '0 :
                   retry_evt ? cnt_r + CNT_W'(1) : cnt_r; // RQ4

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r    <= '0;
      tabort_r <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      tabort_r <= retry_hit; // RQ4
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mbox_en_r <= 1'b0;
      mask_r    <= '0;
    end else begin
      if (wr_ics) mbox_en_r <= rif.wr_data[`BAMS_BIT_MBEN]; // RQ6
      if (wr_mask) mask_r <= rif.wr_data[`BAMS_N_EVT-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(evt_r & mask_r);
    end
  end

  assign tabort_issue = tabort_r;
  assign irq          = irq_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_dm_abort_flag: assert property (evt_set[`BAMS_EVT_DM] |=> !ics_word[`BAMS_BIT_DM_ABT]) // RQ1
    else $error("direct master abort not shown at bit 24");
  a_dma0_abort_flag: assert property (abort_evt && abort_owner == BAMS_OWN_DMA0 |=> !rif.rd_data[`BAMS_BIT_DMA0_ABT] || !rd_ics) // RQ2
    else $error("dma0 abort not shown at bit 25");
  a_dma1_abort_flag: assert property (abort_evt && abort_owner == BAMS_OWN_DMA1 ##1 rd_ics |-> !rif.rd_data[`BAMS_BIT_DMA1_ABT]) // RQ3
    else $error("dma1 abort not shown at bit 26");
  a_retry_abort_issue: assert property (retry_hit |=> tabort_r && !ics_word[`BAMS_BIT_RTY_ABT] && cnt_r == '0) // RQ4
    else $error("retry limit did not raise target abort");
  a_retry_count_step: assert property (retry_evt && !retry_clr && !retry_hit |=> cnt_r == $past(cnt_r) + CNT_W'(1)) // RQ4
    else $error("retry counter did not advance");
  a_no_early_abort: assert property ($rose(tabort_r) |-> $past(cnt_r) == CNT_W'(RETRY_LIMIT - 1)) // RQ4
    else $error("target abort before the retry limit");
  a_mbox_set_flag: assert property (mbox_wr[2] && mbox_en_r |=> ics_word[`BAMS_BIT_MB_LO + 2]) // RQ5
    else $error("mailbox 2 write not flagged");
  a_mbox_gated_enable: assert property ((evt_r[`BAMS_EVT_MB_LO +: `BAMS_N_MBOX] &
      ~$past(evt_r[`BAMS_EVT_MB_LO +: `BAMS_N_MBOX])) != '0 |-> $past(mbox_en_r)) // RQ6
    else $error("mailbox flag set while disabled");
  a_set_over_clear: assert property (evt_set[`BAMS_EVT_DM] && evt_clr[`BAMS_EVT_DM] |=> evt_r[`BAMS_EVT_DM])
    else $error("clear overrode a same-cycle event");
  a_irq_follows_mask: assert property ((evt_r & mask_r) != '0 ##1 (evt_r & mask_r) != '0 |-> irq_r)
    else $error("interrupt low while unmasked status set");

  c_dm_abort: cover property (abort_evt && abort_owner == BAMS_OWN_DM ##1 rd_ics);
  c_retry_abort: cover property (retry_hit ##1 tabort_r);
  c_mbox_irq: cover property (evt_set[`BAMS_EVT_MB_LO] && mask_r[`BAMS_EVT_MB_LO] ##2 irq_r);
endmodule : bams_top

// ### sim/bams_evt_model.sv
// Purpose: bridge side event source for the status block
// Assumes: one pulse per call, launched just after a rising edge
// Notes:   owner code is scrambled while no abort is flagged
`timescale 1ns/100ps
module bams_evt_model import bams_pkg::*; (
  // clock
  input  wire logic        aclk,
  // events toward the block
  output logic             abort_evt,
  output bams_owner_t      abort_owner,
  output logic             retry_evt,
  output logic             retry_clr,
  output logic [3:0]       mbox_wr
);
  initial begin
    abort_evt   = 1'b0;
    abort_owner = bams_owner_t'(3'h6);
    retry_evt   = 1'b0;
    retry_clr   = 1'b0;
    mbox_wr     = 4'h0;
  end

  task automatic abort(input logic [2:0] own);
    @(posedge aclk);
    abort_evt   <= 1'b1;
    abort_owner <= bams_owner_t'(own);
    @(posedge aclk);
    abort_evt   <= 1'b0;
    abort_owner <= bams_owner_t'(~own);
  endtask : abort

  // back to back retries to one target
  task automatic retries(input int n);
    repeat (n) begin
      @(posedge aclk);
      retry_evt <= 1'b1;
    end
    @(posedge aclk);
    retry_evt <= 1'b0;
  endtask : retries

  task automatic clr;
    @(posedge aclk);
    retry_clr <= 1'b1;
    @(posedge aclk);
    retry_clr <= 1'b0;
  endtask : clr

  task automatic mbox(input logic [3:0] m);
    @(posedge aclk);
    mbox_wr <= m;
    @(posedge aclk);
    mbox_wr <= 4'h0;
  endtask : mbox
endmodule : bams_evt_model

// ### sim/bams_top_test.sv
// Purpose: self-checking bench for the abort and mailbox status block
// Assumes: retry limit shortened to 4 cycles of retry
// Notes:   events come from the bridge model, registers over axi4-lite
`timescale 1ns/100ps
module bams_top_test import bams_pkg::*; ;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        abort_evt, retry_evt, retry_clr, tabort_issue, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, mbox_wr, f;
  logic [1:0]  bresp, rresp;
  bams_owner_t abort_owner;
  int          err_count, checked, tabs;

  bams_top #(.RETRY_LIMIT(4)) uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .abort_evt, .abort_owner, .retry_evt, .retry_clr, .mbox_wr, .tabort_issue, .irq);
  bams_evt_model m (.aclk, .abort_evt, .abort_owner, .retry_evt, .retry_clr, .mbox_wr);

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  always @(posedge aclk) if (tabort_issue === 1'b1) tabs++;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    if (n >= 50) err_count++;
    chk({30'h0, bresp}, {30'h0, er}, "bresp");
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    if (n >= 50) err_count++;
    chk(rdata, ed, "rdata");
    chk({30'h0, rresp}, {30'h0, er}, "rresp");
  endtask : rd

  task automatic t_reset;
    rd(8'h00, 32'h0F00_0000);
    chk({31'h0, irq}, 32'h0, "irq idle");
    wr(8'h00, 32'hF000_0008, 2'h0);
    rd(8'h00, 32'h0F00_0008);
    wr(8'h00, 32'h0, 2'h0);
    $display("reset test done");
  endtask : t_reset

  // each owner in turn, plus a code that names none
  task automatic t_abort;
    wr(8'h08, 32'hFF, 2'h0);
    rd(8'h08, 32'hFF);
    for (int i = 0; i < 3; i++) begin
      m.abort(3'h1 << i);
      rd(8'h00, 32'h0F00_0000 & ~(32'h1 << (24 + i)));
      chk({31'h0, irq}, 32'h1, "irq set");
      rd(8'h04, 32'h1 << i);
      wr(8'h04, 32'h1 << i, 2'h0);
      rd(8'h04, 32'h0);
      chk({31'h0, irq}, 32'h0, "irq clear");
      rd(8'h00, 32'h0F00_0000);
    end
    // abort lands in the same cycle as its own clear, set must win
    fork
      wr(8'h04, 32'h1, 2'h0);
      begin
        @(posedge aclk);
        m.abort(3'h1);
      end
    join
    rd(8'h04, 32'h1);
    wr(8'h04, 32'h1, 2'h0);
    m.abort(3'h3);
    rd(8'h00, 32'h0F00_0000);
    $display("abort test done");
  endtask : t_abort

  task automatic t_retry;
    wr(8'h08, 32'h0, 2'h0);
    tabs = 0;
    m.retries(3);
    m.clr();
    m.retries(3);
    rd(8'h00, 32'h0F00_0000);
    chk(tabs, 32'h0, "early abort");
    m.retries(1);
    rd(8'h00, 32'h0700_0000);
    chk(tabs, 32'h1, "abort pulse");
    chk({31'h0, irq}, 32'h0, "irq masked");
    rd(8'h0C, 32'h0);
    rd(8'h04, 32'h8);
    wr(8'h04, 32'h8, 2'h0);
    rd(8'h00, 32'h0F00_0000);
    $display("retry test done");
  endtask : t_retry

  task automatic t_mbox;
    m.mbox(4'hF);
    rd(8'h00, 32'h0F00_0000);
    rd(8'h04, 32'h0);
    wr(8'h00, 32'h8, 2'h0);
    wr(8'h08, 32'hF0, 2'h0);
    f = 4'h0;
    for (int i = 0; i < 4; i++) begin
      m.mbox(4'h1 << i);
      f = f | (4'h1 << i);
      rd(8'h00, 32'h0F00_0008 | {f, 28'h0});
    end
    rd(8'h04, 32'hF0);
    chk({31'h0, irq}, 32'h1, "mailbox irq set");
    wr(8'h04, 32'hF0, 2'h0);
    rd(8'h00, 32'h0F00_0008);
    chk({31'h0, irq}, 32'h0, "mailbox irq clear");
    wr(8'h08, 32'h0, 2'h0);
    wr(8'h00, 32'h0, 2'h0);
    $display("mailbox test done");
  endtask : t_mbox

  task automatic t_map;
    // no byte lane 0, the mask write must not act
    wstrb <= 4'hE;
    wr(8'h08, 32'hFF, 2'h0);
    wstrb <= 4'hF;
    rd(8'h08, 32'h0);
    wr(8'h0C, 32'h5, 2'h0);
    rd(8'h0C, 32'h0);
    wr(8'h10, 32'h1, 2'h2);
    rd(8'h10, 32'h0, 2'h2);
    $display("map test done");
  endtask : t_map

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #400000;
    err_count++;
    end_of_test();
  end

  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    arvalid = 1'b0;
    rready  = 1'b0;
    awaddr  = 8'h00;
    araddr  = 8'h00;
    wdata   = 32'h0;
    wstrb   = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_abort();
    t_retry();
    t_mbox();
    t_map();
    end_of_test();
  end
endmodule : bams_top_test
